// ---- odc_aux_pin.sv ----
`timescale 1ns/1ps
module odc_aux_pin
  import odc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic [1:0] mode, // 00 off, 01 input, 10 low, 11 high
  input wire logic pin_in, // level seen on the pin
  output logic pin_out, // level driven when enabled
  output logic pin_oe_n, // low while driving
  output logic pin_value // sampled input, low when input disabled
);

  always_comb begin
    pin_out = mode[0]; // [RULE17]
    pin_oe_n = ~mode[1]; // [RULE17]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_value <= 1'b0;
    end else begin
      pin_value <= (mode == 2'b01) ? pin_in : 1'b0; // [RULE17]
    end
  end

endmodule

// ---- odc_decoder.sv ----
`timescale 1ns/1ps
module odc_decoder
  import odc_pkg::*;
(
  input wire logic clk, // 125 MHz clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic reset_in_low, // device reset pin, active low
  input wire logic byte_valid, // one-cycle strobe for byte_data
  input wire logic [7:0] byte_data, // received command, parameter or pixel byte
  input wire logic dc_sel, // low: command or parameter, high: pixel data
  output odc_cfg_s cfg, // held configuration
  output logic [GRAY_LEVELS*8-1:0] gray_width, // level n at bits 8n-1..8n-8
  output odc_ptr_s ptr, // current frame memory address
  output logic mem_wr, // pixel byte accepted for frame memory
  output logic [7:0] mem_data, // pixel byte with nibble remap applied
  output odc_ptr_s mem_addr, // address of accepted pixel byte
  output logic busy, // parameter bytes still expected
  input wire logic [1:0] aux_in, // aux pin input levels
  output logic [1:0] aux_out, // aux pin drive levels
  output logic [1:0] aux_oe_n, // aux pin enables, low drives
  output logic [1:0] aux_value // aux pin read values
);

  logic rst_s1_q;
  logic rst_n;
  odc_cfg_s cfg_q;
  odc_state_e state_q;
  logic [7:0] opcode_q;
  logic [3:0] idx_q;
  logic [3:0] need;
  logic cmd_byte;
  logic opcode_take;
  logic param_take;
  logic lin_load;
  logic gray_we;
  logic data_take;
  odc_ptr_s ptr_q;
  logic [7:0] gray_q [GRAY_LEVELS];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // parameter count per opcode
  always_comb begin
    case (byte_data)
      OP_COL, OP_ROW, OP_SCROLL: need = 4'd2; // [RULE24]
      OP_CONTRAST, OP_REMAP, OP_START, OP_OFFSET, OP_MUX,
      OP_VDD, OP_REFERENCE_CURRENT, OP_PHASE, OP_CLKDIV, OP_AUX, OP_PRE2,
      OP_PREV, OP_PRECAP, OP_VCOMH, OP_FADE, OP_LOCK: need = 4'd1;
      OP_GRAY: need = 4'(GRAY_LEVELS); // [RULE19]
      default: need = 4'd0;
    endcase
  end

  // bytes that arrive while the reset pin is low are dropped, not parsed
  assign cmd_byte = byte_valid && !dc_sel && reset_in_low; // [RULE24]
  // while locked every opcode but the lock command is dropped; its parameter bytes are then read as opcodes
  assign opcode_take = cmd_byte && state_q == ODC_ST_OPCODE &&
                       (!cfg_q.locked || byte_data == OP_LOCK); // [RULE23]
  assign param_take = cmd_byte && state_q == ODC_ST_PARAM;
  assign data_take = byte_valid && dc_sel && !cfg_q.locked; // [RULE23]
  assign lin_load = opcode_take && byte_data == OP_LINEAR;
  assign gray_we = param_take && opcode_q == OP_GRAY;

  function automatic logic [3:0] need_of(input logic [7:0] op);
    logic [3:0] n;
    n = 4'd1;
    if (op == OP_COL || op == OP_ROW || op == OP_SCROLL) begin
      n = 4'd2;
    end else if (op == OP_GRAY) begin
      n = 4'(GRAY_LEVELS);
    end
    return n;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ODC_ST_OPCODE;
      opcode_q <= 8'h00;
      idx_q <= 4'h0;
    end else if (!reset_in_low) begin
      state_q <= ODC_ST_OPCODE; // [RULE1]
      opcode_q <= 8'h00;
      idx_q <= 4'h0;
    end else if (opcode_take) begin
      opcode_q <= byte_data;
      idx_q <= 4'h0;
      if (need != 4'd0) begin
        state_q <= ODC_ST_PARAM; // [RULE24]
      end
    end else if (param_take) begin
      idx_q <= idx_q + 4'd1;
      if (idx_q + 4'd1 == need_of(opcode_q)) begin
        state_q <= ODC_ST_OPCODE; // [RULE24]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RST;
    end else if (!reset_in_low) begin
      cfg_q <= CFG_RST; // [RULE1]
    end else if (opcode_take) begin
      case (byte_data)
        OP_MODE_NORMAL: cfg_q.mode <= ODC_MODE_NORMAL; // [RULE10]
        OP_MODE_ON: cfg_q.mode <= ODC_MODE_ALL_ON; // [RULE10]
        OP_MODE_OFF: cfg_q.mode <= ODC_MODE_ALL_OFF; // [RULE10]
        OP_MODE_INV: cfg_q.mode <= ODC_MODE_INVERSE; // [RULE10]
        OP_DISP_OFF: cfg_q.display_on <= 1'b0; // [RULE14]
        OP_DISP_ON: cfg_q.display_on <= 1'b1; // [RULE14]
        default: ;
      endcase
    end else if (param_take) begin
      case (opcode_q)
        OP_COL: begin
          if (idx_q == 4'd0) begin
            cfg_q.col_start <= byte_data[6:0]; // [RULE2]
          end else begin
            cfg_q.col_end <= byte_data[6:0]; // [RULE2]
          end
        end
        OP_ROW: begin
          if (idx_q == 4'd0) begin
            cfg_q.row_start <= byte_data[5:0]; // [RULE3]
          end else begin
            cfg_q.row_end <= byte_data[5:0]; // [RULE3]
          end
        end
        OP_SCROLL: begin
          // the scroll count is taken as given; fitting it is the host's job
          if (idx_q == 4'd0) begin
            cfg_q.fixed_rows <= byte_data[5:0]; // [RULE8]
          end else begin
            cfg_q.scroll_rows <= byte_data[6:0]; // [RULE8]
          end
        end
        OP_CONTRAST: cfg_q.contrast <= byte_data; // [RULE4]
        OP_REMAP: cfg_q.remap <= byte_data & REMAP_MASK; // [RULE5]
        OP_START: cfg_q.start_line <= byte_data[5:0]; // [RULE6]
        OP_OFFSET: cfg_q.offset <= byte_data[5:0]; // [RULE7]
        OP_MUX: cfg_q.multiplex_ratio <= byte_data[5:0]; // [RULE11]
        OP_VDD: cfg_q.vdd_internal <= byte_data[VDD_BIT]; // [RULE12]
        OP_REFERENCE_CURRENT: cfg_q.reference_current_internal <= byte_data[REFERENCE_CURRENT_BIT]; // [RULE13]
        OP_PHASE: cfg_q.phase <= byte_data; // [RULE15]
        OP_CLKDIV: cfg_q.clkdiv <= byte_data; // [RULE16]
        OP_AUX: cfg_q.aux_mode <= byte_data[3:0]; // [RULE17]
        OP_PRE2: cfg_q.precharge2 <= byte_data[3:0]; // [RULE18]
        OP_PREV: cfg_q.precharge_v <= byte_data[4:0]; // [RULE22]
        OP_LOCK: cfg_q.locked <= byte_data[LOCK_BIT]; // [RULE23]
        default: ;
      endcase
    end
  end

  // gray table, one entry per level; level 0 has no drive and no entry
  for (genvar k = 0; k < GRAY_LEVELS; k++) begin : g_gray
    localparam logic [7:0] LIN = 8'((k + 1) * GRAY_STEP);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        gray_q[k] <= LIN;
      end else if (lin_load) begin
        gray_q[k] <= LIN; // [RULE21]
      end else if (gray_we && idx_q == 4'(k)) begin
        gray_q[k] <= byte_data; // [RULE19]
      end
    end
    assign gray_width[k*8 +: 8] = gray_q[k];
  end

  // address pointers step through the window on each pixel byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= '0;
    end else if (!reset_in_low) begin
      ptr_q <= '0; // [RULE1]
    end else if (param_take && opcode_q == OP_COL && idx_q == 4'd0) begin
      ptr_q.col <= byte_data[6:0]; // [RULE2]
    end else if (param_take && opcode_q == OP_ROW && idx_q == 4'd0) begin
      ptr_q.row <= byte_data[5:0]; // [RULE3]
    end else if (data_take) begin
      if (cfg_q.remap[REMAP_VERT_BIT]) begin
        if (ptr_q.row == cfg_q.row_end) begin
          ptr_q.row <= cfg_q.row_start;
          ptr_q.col <= (ptr_q.col == cfg_q.col_end) ? cfg_q.col_start : ptr_q.col + 7'd1;
        end else begin
          ptr_q.row <= ptr_q.row + 6'd1;
        end
      end else begin
        if (ptr_q.col == cfg_q.col_end) begin
          ptr_q.col <= cfg_q.col_start;
          ptr_q.row <= (ptr_q.row == cfg_q.row_end) ? cfg_q.row_start : ptr_q.row + 6'd1;
        end else begin
          ptr_q.col <= ptr_q.col + 7'd1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr <= 1'b0;
      mem_data <= 8'h00;
      mem_addr <= '0;
    end else begin
      mem_wr <= data_take && reset_in_low; // [RULE23]
      if (data_take) begin
        mem_data <= cfg_q.remap[1] ? {byte_data[3:0], byte_data[7:4]} : byte_data; // [RULE5]
        mem_addr <= ptr_q;
      end
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_aux
    odc_aux_pin u_pin (
      .clk(clk),
      .rst_n(rst_n),
      .mode(cfg_q.aux_mode[p*2 +: 2]),
      .pin_in(aux_in[p]),
      .pin_out(aux_out[p]),
      .pin_oe_n(aux_oe_n[p]),
      .pin_value(aux_value[p])
    );
  end

  assign cfg = cfg_q;
  assign ptr = ptr_q;
  assign busy = state_q == ODC_ST_PARAM;

endmodule

// ---- odc_decoder_checker.sv ----
`timescale 1ns/1ps
module odc_decoder_checker
  import odc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic arst_n, // async reset
  input wire logic reset_in_low, // reset pin
  input wire logic byte_valid, // byte strobe
  input wire logic [7:0] byte_data, // host byte
  input wire logic dc_sel, // data select
  input wire odc_cfg_s cfg, // settings
  input wire logic [GRAY_LEVELS*8-1:0] gray_width, // gray table
  input wire logic mem_wr, // pixel write
  input wire logic [7:0] mem_data, // pixel byte
  input wire logic busy, // params pending
  input wire logic [1:0] aux_out, // aux level
  input wire logic [1:0] aux_oe_n // aux enable
);
  logic op_ok;
  logic [7:0] last_op_q;
  assign op_ok = byte_valid && !dc_sel && !busy && reset_in_low && !cfg.locked;
  // remembers the opcode whose parameters are being collected
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_op_q <= 8'h00;
    end else if (op_ok) begin
      last_op_q <= byte_data;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_pin_defaults: assert property (!reset_in_low |=> cfg == CFG_RST)
    else $error("settings not at defaults after reset pin");
  a_display_onoff: assert property (op_ok && byte_data[7:1] == 7'h57
    |=> cfg.display_on == $past(byte_data[0])) else $error("display on/off wrong");
  a_mode_select: assert property (op_ok && byte_data[7:2] == 6'h29
    |=> cfg.mode == $past(byte_data[1:0])) else $error("display mode wrong");
  a_param_busy: assert property (op_ok && byte_data == OP_CONTRAST |=> busy)
    else $error("no parameter expected after opcode");
  a_contrast_param: assert property (busy && last_op_q == OP_CONTRAST && byte_valid
    && !dc_sel && reset_in_low |=> cfg.contrast == $past(byte_data) && !busy)
    else $error("contrast not taken");
  a_remap_param: assert property (busy && last_op_q == OP_REMAP && byte_valid
    && !dc_sel && reset_in_low |=> cfg.remap == ($past(byte_data) & 8'hd7))
    else $error("remap not taken");
  a_lock_ignores: assert property (cfg.locked && byte_valid && !dc_sel && !busy
    && reset_in_low && byte_data != OP_LOCK |=> $stable(cfg)) else $error("locked change");
  a_lock_no_write: assert property (cfg.locked && byte_valid && dc_sel |=> !mem_wr)
    else $error("pixel write while locked");
  a_data_writes: assert property (byte_valid && dc_sel && reset_in_low && !cfg.locked
    |=> mem_wr && $stable(cfg)) else $error("pixel byte mishandled");
  a_nibble_swap: assert property (mem_wr && cfg.remap[1]
    |-> mem_data == {$past(byte_data[3:0]), $past(byte_data[7:4])}) else $error("nibbles");
  a_linear_table: assert property (op_ok && byte_data == OP_LINEAR
    |=> gray_width[7:0] == 8'h0c && gray_width[119:112] == 8'hb4) else $error("linear");
  a_aux_drive: assert property (cfg.aux_mode[3] |-> !aux_oe_n[1]
    && aux_out[1] == cfg.aux_mode[2]) else $error("aux pin not driven");
  c_gray_load: cover property (op_ok && byte_data == OP_GRAY);
  c_locked_cmd: cover property (cfg.locked && byte_valid && !dc_sel);
  c_vert_write: cover property (mem_wr && cfg.remap[2]);
endmodule
bind odc_decoder odc_decoder_checker i_chk (.clk, .arst_n, .reset_in_low, .byte_valid,
  .byte_data, .dc_sel, .cfg, .gray_width, .mem_wr, .mem_data, .busy, .aux_out, .aux_oe_n);

// ---- odc_host.sv ----
`timescale 1ns/1ps
module odc_host (
  input wire logic clk, // clock
  output logic byte_valid, // byte strobe
  output logic [7:0] byte_data, // byte to decoder
  output logic dc_sel // 0 command, 1 pixel
);
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    dc_sel = 1'b0;
  end
  // released lines show the inverse so stale values are never trusted
  task automatic put(input logic dc, input logic [7:0] b);
    @(posedge clk);
    #1;
    byte_valid = 1'b1;
    dc_sel = dc;
    byte_data = b;
    @(posedge clk);
    #1;
    byte_valid = 1'b0;
    dc_sel = ~dc;
    byte_data = ~b;
  endtask
endmodule

// ---- odc_pkg.sv ----
// How it works
// RULE1: reset pin low: display off, normal maps, parser cleared, start line zero, contrast 7Fh.
// RULE2: 15h takes 7-bit column window start and end, defaults 00h and 7Fh.
// RULE3: 75h takes 6-bit row window start and end, defaults 00h and 3Fh.
// RULE4: 81h takes an 8-bit contrast step, reset 7Fh.
// RULE5: A0h loads remap bits 0,1,2,4,6,7; bit 6 resets to one.
// RULE6: A1h takes a 6-bit display start line, default zero.
// RULE7: A2h takes a 6-bit vertical offset, default zero.
// RULE8: A3h takes 6-bit fixed rows (0) and 7-bit scroll rows (40h).
// RULE9: host keeps fixed plus scroll rows and start line within the multiplex ratio.
// RULE10: A4h..A7h select normal, all level 15, all level 0, inverse.
// RULE11: A8h takes 6-bit multiplex value N, reset 63; host never sends 0..2.
// RULE12: ABh bit 0 selects internal core regulator (1, reset) or external supply.
// RULE13: ADh bit 4 selects internal reference current (1) or external (0, reset).
// RULE14: AEh turns display off (reset), AFh turns it on.
// RULE15: B1h low nibble phase one (0010b), high nibble phase two (1000b).
// RULE16: B3h low nibble clock divide code (0001b), high nibble oscillator code (1010b).
// RULE17: B5h gives each aux pin a 2-bit mode; drive low is reset.
// RULE18: B6h takes a 4-bit second pre-charge period, default 0100b.
// RULE19: B8h takes next 15 bytes as widths for gray levels 1 to 15.
// RULE20: host loads strictly increasing widths; level 15 above phases sum and 140.
// RULE21: B9h loads the linear table, level n width 12 times n.
// RULE22: BCh takes a 5-bit pre-charge voltage code, default 04h.
// RULE23: while locked, ignore all commands and memory writes except FDh; reset unlocks.
// RULE24: only select-low bytes are commands; parameters are counted per opcode first.
package odc_pkg;

  localparam logic [7:0] OP_COL = 8'h15;
  localparam logic [7:0] OP_ROW = 8'h75;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_REMAP = 8'ha0;
  localparam logic [7:0] OP_START = 8'ha1;
  localparam logic [7:0] OP_OFFSET = 8'ha2;
  localparam logic [7:0] OP_SCROLL = 8'ha3;
  localparam logic [7:0] OP_MODE_NORMAL = 8'ha4;
  localparam logic [7:0] OP_MODE_ON = 8'ha5;
  localparam logic [7:0] OP_MODE_OFF = 8'ha6;
  localparam logic [7:0] OP_MODE_INV = 8'ha7;
  localparam logic [7:0] OP_MUX = 8'ha8;
  localparam logic [7:0] OP_VDD = 8'hab;
  localparam logic [7:0] OP_REFERENCE_CURRENT = 8'had;
  localparam logic [7:0] OP_DISP_OFF = 8'hae;
  localparam logic [7:0] OP_DISP_ON = 8'haf;
  localparam logic [7:0] OP_PHASE = 8'hb1;
  localparam logic [7:0] OP_CLKDIV = 8'hb3;
  localparam logic [7:0] OP_AUX = 8'hb5;
  localparam logic [7:0] OP_PRE2 = 8'hb6;
  localparam logic [7:0] OP_GRAY = 8'hb8;
  localparam logic [7:0] OP_LINEAR = 8'hb9;
  localparam logic [7:0] OP_PREV = 8'hbc;
  localparam logic [7:0] OP_PRECAP = 8'hbd;
  localparam logic [7:0] OP_VCOMH = 8'hbe;
  localparam logic [7:0] OP_FADE = 8'h23;
  localparam logic [7:0] OP_LOCK = 8'hfd;

  localparam int LOCK_BIT = 2;
  localparam int VDD_BIT = 0;
  localparam int REFERENCE_CURRENT_BIT = 4;

  localparam logic [6:0] COL_START_RST = 7'h00;
  localparam logic [6:0] COL_END_RST = 7'h7f;
  localparam logic [5:0] ROW_START_RST = 6'h00;
  localparam logic [5:0] ROW_END_RST = 6'h3f;
  localparam logic [7:0] CONTRAST_RST = 8'h7f;
  localparam logic [7:0] REMAP_RST = 8'h40;
  localparam logic [7:0] REMAP_MASK = 8'hd7;
  localparam int REMAP_VERT_BIT = 2;
  localparam logic [5:0] START_RST = 6'h00;
  localparam logic [5:0] OFFSET_RST = 6'h00;
  localparam logic [5:0] FIXED_RST = 6'h00;
  localparam logic [6:0] SCROLL_RST = 7'h40;
  localparam logic [5:0] MUX_RST = 6'h3f;
  localparam logic [7:0] PHASE_RST = 8'h82;
  localparam logic [7:0] CLKDIV_RST = 8'ha1;
  localparam logic [3:0] AUX_RST = 4'ha;
  localparam logic [3:0] PRE2_RST = 4'h4;
  localparam logic [4:0] PREV_RST = 5'h04;
  localparam int GRAY_LEVELS = 15;
  localparam int GRAY_STEP = 12;

  typedef enum logic [1:0] {
    ODC_MODE_NORMAL,
    ODC_MODE_ALL_ON,
    ODC_MODE_ALL_OFF,
    ODC_MODE_INVERSE
  } odc_mode_e;

  typedef enum logic {
    ODC_ST_OPCODE,
    ODC_ST_PARAM
  } odc_state_e;

  typedef struct packed {
    logic [6:0] col_start;
    logic [6:0] col_end;
    logic [5:0] row_start;
    logic [5:0] row_end;
    logic [7:0] contrast;
    logic [7:0] remap;
    logic [5:0] start_line;
    logic [5:0] offset;
    logic [5:0] fixed_rows;
    logic [6:0] scroll_rows;
    odc_mode_e mode;
    logic [5:0] multiplex_ratio;
    logic vdd_internal;
    logic reference_current_internal;
    logic display_on;
    logic [7:0] phase;
    logic [7:0] clkdiv;
    logic [3:0] aux_mode;
    logic [3:0] precharge2;
    logic [4:0] precharge_v;
    logic locked;
  } odc_cfg_s;

  localparam odc_cfg_s CFG_RST = '{
    col_start: COL_START_RST, col_end: COL_END_RST,
    row_start: ROW_START_RST, row_end: ROW_END_RST,
    contrast: CONTRAST_RST, remap: REMAP_RST,
    start_line: START_RST, offset: OFFSET_RST,
    fixed_rows: FIXED_RST, scroll_rows: SCROLL_RST,
    mode: ODC_MODE_NORMAL, multiplex_ratio: MUX_RST,
    vdd_internal: 1'b1, reference_current_internal: 1'b0, display_on: 1'b0,
    phase: PHASE_RST, clkdiv: CLKDIV_RST, aux_mode: AUX_RST,
    precharge2: PRE2_RST, precharge_v: PREV_RST, locked: 1'b0
  };

  typedef struct packed {
    logic [6:0] col;
    logic [5:0] row;
  } odc_ptr_s;

endpackage

// ---- tb_oled_driver_command_decoder.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_oled_driver_command_decoder;
  import odc_pkg::*;
  logic clk, arst_n, reset_in_low, byte_valid, dc_sel, mem_wr, busy;
  logic [7:0] byte_data, mem_data;
  odc_cfg_s cfg;
  logic [GRAY_LEVELS*8-1:0] gray_width;
  odc_ptr_s ptr, mem_addr;
  logic [1:0] aux_in, aux_out, aux_oe_n, aux_value, ext_lvl;
  int fails, n_compared;
  odc_decoder i_dut (.clk, .arst_n, .reset_in_low, .byte_valid, .byte_data, .dc_sel,
    .cfg, .gray_width, .ptr, .mem_wr, .mem_data, .mem_addr, .busy, .aux_in, .aux_out,
    .aux_oe_n, .aux_value);
  odc_host i_host (.clk, .byte_valid, .byte_data, .dc_sel);
  assign aux_in = (aux_out & ~aux_oe_n) | (ext_lvl & aux_oe_n);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic cmd(input logic [7:0] op, input logic [7:0] p0, input logic [7:0] p1,
      input int n);
    i_host.put(1'b0, op);
    if (n > 0) i_host.put(1'b0, p0);
    if (n > 1) i_host.put(1'b0, p1);
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  initial begin
    arst_n = 1'b0;
    reset_in_low = 1'b1;
    ext_lvl = 2'b11;
    fails = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(cfg, CFG_RST)
    `CHK({cfg.contrast, cfg.remap, cfg.phase, cfg.clkdiv}, 32'h7f4082a1)
    `CHK({cfg.scroll_rows, cfg.multiplex_ratio, cfg.aux_mode, cfg.precharge2}, 21'h103fa4)
    `CHK({cfg.col_end, cfg.row_end, cfg.precharge_v, cfg.vdd_internal, cfg.display_on},
      20'hfff92)
    for (int k = 1; k <= 15; k++) `CHK(gray_width[8*k-1 -: 8], 8'(12 * k))
    i_host.put(1'b0, OP_CONTRAST);
    `CHK(busy, 1'b1)
    i_host.put(1'b1, 8'h66);
    `CHK(mem_wr, 1'b1)
    `CHK(ptr, 13'h0040)
    i_host.put(1'b0, 8'h33);
    `CHK({busy, cfg.contrast}, 9'h033)
    cmd(OP_MUX, 8'h3e, 8'h00, 1);
    `CHK(cfg.multiplex_ratio, 6'h3e)
    cmd(OP_SCROLL, 8'h08, 8'h30, 2);
    `CHK({cfg.fixed_rows, cfg.scroll_rows}, 13'h0430)
    cmd(OP_START, 8'h1f, 8'h00, 1);
    `CHK(cfg.start_line, 6'h1f)
    cmd(OP_OFFSET, 8'h2a, 8'h00, 1);
    `CHK(cfg.offset, 6'h2a)
    for (int m = 0; m < 4; m++) begin
      cmd(8'ha4 + 8'(m), 8'h00, 8'h00, 0);
      `CHK(cfg.mode, odc_mode_e'(m))
    end
    cmd(OP_VDD, 8'h00, 8'h00, 1);
    `CHK(cfg.vdd_internal, 1'b0)
    cmd(OP_REFERENCE_CURRENT, 8'h10, 8'h00, 1);
    `CHK(cfg.reference_current_internal, 1'b1)
    cmd(OP_DISP_ON, 8'h00, 8'h00, 0);
    `CHK(cfg.display_on, 1'b1)
    cmd(OP_DISP_OFF, 8'h00, 8'h00, 0);
    `CHK(cfg.display_on, 1'b0)
    cmd(OP_PHASE, 8'h5c, 8'h00, 1);
    `CHK(cfg.phase, 8'h5c)
    cmd(OP_CLKDIV, 8'hf7, 8'h00, 1);
    `CHK(cfg.clkdiv, 8'hf7)
    cmd(OP_PRE2, 8'h0f, 8'h00, 1);
    `CHK(cfg.precharge2, 4'hf)
    cmd(OP_PREV, 8'h1f, 8'h00, 1);
    `CHK(cfg.precharge_v, 5'h1f)
    cmd(OP_FADE, OP_CONTRAST, 8'h00, 1);
    cmd(OP_VCOMH, OP_CONTRAST, 8'h00, 1);
    cmd(OP_PRECAP, OP_CONTRAST, 8'h00, 1);
    cmd(8'h00, 8'h00, 8'h00, 0);
    `CHK({busy, cfg.contrast}, 9'h033)
    cmd(OP_AUX, 8'h07, 8'h00, 1);
    @(posedge clk);
    #1;
    `CHK({aux_oe_n, aux_out, aux_value}, 6'h2e)
    cmd(OP_AUX, 8'h04, 8'h00, 1);
    @(posedge clk);
    #1;
    `CHK({aux_oe_n, aux_value}, 4'he)
    cmd(OP_AUX, 8'h05, 8'h00, 1);
    @(posedge clk);
    #1;
    `CHK(aux_value, 2'h3)
    cmd(OP_GRAY, 8'h00, 8'h00, 0);
    for (int k = 1; k <= 15; k++) i_host.put(1'b0, 8'(23 + 9 * k));
    for (int k = 1; k <= 15; k++) `CHK(gray_width[8*k-1 -: 8], 8'(23 + 9 * k))
    cmd(OP_LINEAR, 8'h00, 8'h00, 0);
    for (int k = 1; k <= 15; k++) `CHK(gray_width[8*k-1 -: 8], 8'(12 * k))
    cmd(OP_REMAP, 8'hff, 8'h00, 1);
    `CHK(cfg.remap, 8'hd7)
    cmd(OP_COL, 8'h05, 8'h7a, 2);
    `CHK({cfg.col_start, cfg.col_end}, 14'h02fa)
    cmd(OP_ROW, 8'h02, 8'h3d, 2);
    `CHK({cfg.row_start, cfg.row_end}, 12'h0bd)
    `CHK(ptr, 13'h0142)
    i_host.put(1'b1, 8'ha5);
    `CHK(mem_data, 8'h5a)
    i_host.put(1'b1, 8'h3c);
    `CHK(mem_addr, 13'h0143)
    `CHK(ptr, 13'h0144)
    cmd(OP_LOCK, 8'h04, 8'h00, 1);
    `CHK(cfg.locked, 1'b1)
    cmd(OP_CONTRAST, 8'h99, 8'h00, 1);
    `CHK(cfg.contrast, 8'h33)
    i_host.put(1'b1, 8'h11);
    `CHK(mem_wr, 1'b0)
    cmd(OP_LOCK, 8'h00, 8'h00, 1);
    `CHK(cfg.locked, 1'b0)
    @(posedge clk);
    #1 reset_in_low = 1'b0;
    @(posedge clk);
    #1 reset_in_low = 1'b1;
    `CHK(cfg, CFG_RST)
    `CHK(ptr, 13'h0000)
    give_verdict();
  end
endmodule
